//--- hw/irq_pkg.sv
// Shared constants, tables and state types of the interrupt controller.
// Assumes every user imports the whole package.
package irq_pkg;

    localparam int NUM_PERIPH = 12;
    localparam int NUM_SRC = 13;
    localparam int IDX_W = 4;
    localparam int VEC_W = 16;

    // Source indices
    localparam logic [IDX_W-1:0] SRC_EXT0 = 4'h0;
    localparam logic [IDX_W-1:0] SRC_TMR0 = 4'h1;
    localparam logic [IDX_W-1:0] SRC_EXT1 = 4'h2;
    localparam logic [IDX_W-1:0] SRC_TMR1 = 4'h3;
    localparam logic [IDX_W-1:0] SRC_SER = 4'h4;
    localparam logic [IDX_W-1:0] SRC_TMR2 = 4'h5;
    localparam logic [IDX_W-1:0] SRC_ADC = 4'h6;
    localparam logic [IDX_W-1:0] SRC_EXT2 = 4'h7;
    localparam logic [IDX_W-1:0] SRC_EMRG = 4'h8;
    localparam logic [IDX_W-1:0] SRC_CT2 = 4'h9;
    localparam logic [IDX_W-1:0] SRC_CCM = 4'hA;
    localparam logic [IDX_W-1:0] SRC_CT1 = 4'hB;
    localparam logic [IDX_W-1:0] SRC_WAKE = 4'hC;

    // Vector address per source index
    localparam logic [VEC_W-1:0] VEC_TABLE [NUM_SRC] = '{
        16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
        16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B,
        16'h007B};

    // Polling order, first entry wins
    localparam logic [IDX_W-1:0] POLL_ORDER [NUM_SRC] = '{
        SRC_WAKE,
        SRC_EXT0, SRC_ADC,
        SRC_TMR0, SRC_EXT2,
        SRC_EXT1, SRC_EMRG,
        SRC_TMR1, SRC_CT2,
        SRC_SER, SRC_CCM,
        SRC_TMR2, SRC_CT1};

    typedef enum logic [1:0] {S_IDLE, S_OFFER} fsm_t;

    typedef struct packed {
        fsm_t fsm;
        logic [NUM_PERIPH-1:0] req_smp;
        logic int0_s1;
        logic int0_s2;
        logic nom_s1;
        logic nom_s2;
        logic wake_pend;
        logic irq;
        logic lvl_high;
        logic [IDX_W-1:0] idx;
        logic [VEC_W-1:0] vec;
        logic [NUM_SRC-1:0] clr;
    } ctl_st_t;

    localparam ctl_st_t CTL_RST = '{
        fsm: S_IDLE, req_smp: '0, int0_s1: 1'b1, int0_s2: 1'b1,
        nom_s1: 1'b0, nom_s2: 1'b0, wake_pend: 1'b0, irq: 1'b0,
        lvl_high: 1'b0, idx: '0, vec: '0, clr: '0};

    typedef struct packed {
        logic hi_act;
        logic lo_act;
    } nest_st_t;

    localparam nest_st_t NEST_RST = '{hi_act: 1'b0, lo_act: 1'b0};

    function automatic logic [VEC_W-1:0] vec_of(input logic [IDX_W-1:0] idx);
        if (int'(idx) < NUM_SRC) begin
            return VEC_TABLE[idx];
        end
        return '0;
    endfunction

endpackage

//--- hw/nest_if.sv
// Link between the dispatcher and the nesting tracker.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface nest_if;
    logic enter;
    logic enter_high;
    logic leave;
    logic in_high;
    logic in_low;
    modport ctrl (output enter, output enter_high, output leave, input in_high, input in_low);
    modport track (input enter, input enter_high, input leave, output in_high, output in_low);
endinterface

//--- hw/poll_pick.sv
// Fixed polling encoder for one priority level.
// Assumes candidates are already masked to the level.
`timescale 1ns/10ps
module poll_pick
    import irq_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input wire logic [N-1:0] cand_i,
    output logic found_o,
    output logic [IDX_W-1:0] idx_o
);

    // Walk lowest rank first so the highest rank overwrites
    always_comb begin
        found_o = 1'b0;
        idx_o = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (cand_i[POLL_ORDER[k]]) begin
                found_o = 1'b1;
                idx_o = POLL_ORDER[k];
            end
        end
    end

endmodule // poll_pick

//--- hw/nest_track.sv
// Tracks which priority levels have a routine in service.
// Assumes enter and leave are one-cycle pulses from the dispatcher.
`timescale 1ns/10ps
module nest_track
    import irq_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    nest_if.track nest
);

    nest_st_t st_r;
    nest_st_t st_nxt;

    // Leave first, then enter, so a back-to-back end and entry is kept
    always_comb begin
        st_nxt = st_r;
        if (nest.leave) begin
            if (st_r.hi_act) begin
                st_nxt.hi_act = 1'b0;
            end else begin
                st_nxt.lo_act = 1'b0;
            end
        end
        if (nest.enter) begin
            if (nest.enter_high) begin
                st_nxt.hi_act = 1'b1;
            end else begin
                st_nxt.lo_act = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_r <= NEST_RST;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign nest.in_high = st_r.hi_act;
    assign nest.in_low = st_r.lo_act;

endmodule // nest_track

//--- hw/irq_ctrl.sv
// Two-level vectored interrupt controller, top level.
// Assumes peripherals hold their requests until cleared and the CPU
// pulses ack and end-of-routine on this clock.
//
// How it works
// - Twelve peripheral sources are taken, each set to high or low level by its own bit.
// - A low routine in service lets a high request through but holds every other low one back.
// - A high routine in service blocks every request from reaching the CPU.
// - When both levels are pending in one sample, the high one is offered.
// - Within one level the winner is fixed by the polling order alone.
// - Pairs rank ext0/adc, timer0/ext2, ext1/emergency, timer1/ct2, serial/ccm, timer2/ct1.
// - Ext0, timer0, ext1, timer1, serial and timer2 vector to 0003, 000B, 0013, 001B, 0023, 002B.
// - Compare timer 2 goes to 005B, A/D to 0043, ext2 to 004B and emergency to 0053.
// - Compare timer 1 goes to 006B, capture/compare match to 0063 and wake-up to 007B.
// - Timer 1 beats compare timer 2 inside the fourth pair.
// - Timer 2 beats compare timer 1 inside the last pair.
// - A low ext0 pin in power-down arms the wake-up request, dispatched once the clock is nominal.
`timescale 1ns/10ps
module irq_ctrl
    import irq_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic glob_en_i,
    input wire logic [NUM_PERIPH-1:0] src_req_i,
    input wire logic [NUM_PERIPH-1:0] src_en_i,
    input wire logic [NUM_PERIPH-1:0] src_high_i,
    input wire logic pd_mode_i,
    input wire logic int0_pin_i,
    input wire logic clk_nominal_i,
    input wire logic cpu_ack_i,
    input wire logic cpu_reti_i,
    output logic irq_o,
    output logic [VEC_W-1:0] vector_o,
    output logic level_high_o,
    output logic [NUM_SRC-1:0] src_clr_o,
    output logic in_high_o,
    output logic in_low_o,
    output logic wake_pend_o
);

    ctl_st_t st_r;
    ctl_st_t st_nxt;

    nest_if nest ();

    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] high_sel;
    logic [NUM_SRC-1:0] hi_cand;
    logic [NUM_SRC-1:0] lo_cand;
    logic hi_found;
    logic lo_found;
    logic [IDX_W-1:0] hi_idx;
    logic [IDX_W-1:0] lo_idx;
    logic hi_ok;
    logic lo_ok;
    logic sel_valid;
    logic sel_high;
    logic [IDX_W-1:0] sel_idx;
    logic wake_set;
    logic wake_clr;
    logic take;

    // Wake-up only counts once the clock has settled
    assign pend = {st_r.wake_pend & st_r.nom_s2, st_r.req_smp};

    // Wake-up has no level bit of its own and is always high
    assign high_sel = {1'b1, src_high_i};

    assign hi_cand = pend & high_sel;
    assign lo_cand = pend & ~high_sel;

    poll_pick #(
        .N(NUM_SRC)
    ) u_pick_hi (
        .cand_i(hi_cand),
        .found_o(hi_found),
        .idx_o(hi_idx)
    );

    poll_pick #(
        .N(NUM_SRC)
    ) u_pick_lo (
        .cand_i(lo_cand),
        .found_o(lo_found),
        .idx_o(lo_idx)
    );

    nest_track u_nest (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .nest(nest)
    );

    // Gating by what is already in service
    assign hi_ok = !nest.in_high;
    assign lo_ok = !nest.in_high && !nest.in_low;

    always_comb begin
        sel_valid = 1'b0;
        sel_high = 1'b0;
        sel_idx = '0;
        if (hi_found && hi_ok) begin
            sel_valid = 1'b1;
            sel_high = 1'b1;
            sel_idx = hi_idx;
        end else if (lo_found && lo_ok) begin
            sel_valid = 1'b1;
            sel_high = 1'b0;
            sel_idx = lo_idx;
        end
    end

    // The CPU takes the offer standing at the edge of its ack
    assign take = (st_r.fsm == S_OFFER) && st_r.irq && cpu_ack_i;

    // Pin low while powered down arms the wake-up request
    assign wake_set = pd_mode_i && !st_r.int0_s2;
    assign wake_clr = take && (st_r.idx == SRC_WAKE);

    assign nest.enter = take;
    assign nest.enter_high = st_r.lvl_high;
    assign nest.leave = cpu_reti_i;

    always_comb begin
        st_nxt = st_r;

        // Requests are sampled once per cycle; one sample is one instant
        st_nxt.req_smp = src_req_i & src_en_i & {NUM_PERIPH{glob_en_i}};

        // Pin and oscillator status come from outside this clock
        st_nxt.int0_s1 = int0_pin_i;
        st_nxt.int0_s2 = st_r.int0_s1;
        st_nxt.nom_s1 = clk_nominal_i;
        st_nxt.nom_s2 = st_r.nom_s1;

        // Set beats clear so a fresh wake-up is never lost
        if (wake_set) begin
            st_nxt.wake_pend = 1'b1;
        end else if (wake_clr) begin
            st_nxt.wake_pend = 1'b0;
        end

        st_nxt.clr = '0;

        case (st_r.fsm)
            S_IDLE: begin
                if (sel_valid) begin
                    st_nxt.fsm = S_OFFER;
                    st_nxt.irq = 1'b1;
                    st_nxt.lvl_high = sel_high;
                    st_nxt.idx = sel_idx;
                    st_nxt.vec = vec_of(sel_idx);
                end else begin
                    st_nxt.irq = 1'b0;
                end
            end
            S_OFFER: begin
                if (take) begin
                    // Clear pulse tells the source it was served
                    st_nxt.clr = NUM_SRC'(1) << st_r.idx;
                    st_nxt.fsm = S_IDLE;
                    st_nxt.irq = 1'b0;
                end else if (sel_valid) begin
                    // Follow a newer, higher or withdrawn request
                    st_nxt.lvl_high = sel_high;
                    st_nxt.idx = sel_idx;
                    st_nxt.vec = vec_of(sel_idx);
                end else begin
                    st_nxt.fsm = S_IDLE;
                    st_nxt.irq = 1'b0;
                end
            end
            default: begin
                st_nxt.fsm = S_IDLE;
                st_nxt.irq = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_r <= CTL_RST;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign irq_o = st_r.irq;
    assign vector_o = st_r.vec;
    assign level_high_o = st_r.lvl_high;
    assign src_clr_o = st_r.clr;
    assign in_high_o = nest.in_high;
    assign in_low_o = nest.in_low;
    assign wake_pend_o = st_r.wake_pend;

endmodule // irq_ctrl

//--- test/cpu_model.sv
// CPU side model: takes offered vectors after a set delay, ends routines on request.
// Assumes the controller samples ack and end-of-routine on the rising edge.
`timescale 1ns/10ps
module cpu_model
    import irq_pkg::*;
(
    input wire logic clock_i,
    input wire logic irq_i,
    input wire logic [VEC_W-1:0] vec_i,
    input wire logic [3:0] dly_i,
    input wire logic reti_req_i,
    output logic ack_o,
    output logic reti_o,
    output logic [VEC_W-1:0] taken_o
);
    logic [3:0] cnt_r = 4'h0;
    initial begin
        ack_o = 1'h0;
        reti_o = 1'h0;
        taken_o = 16'h0000;
    end
    // Ack after the offer stood dly_i cycles, so slow takers are covered
    always @(negedge clock_i) begin
        reti_o <= reti_req_i;
        if (irq_i && !ack_o && cnt_r == dly_i) begin
            ack_o <= 1'h1;
            cnt_r <= 4'h0;
        end else if (irq_i && !ack_o) begin
            ack_o <= 1'h0;
            cnt_r <= cnt_r + 4'h1;
        end else begin
            ack_o <= 1'h0;
            cnt_r <= 4'h0;
        end
    end
    // What stands at the ack edge is what the CPU gets
    always @(posedge clock_i) begin
        if (ack_o && irq_i) begin
            taken_o <= vec_i;
        end
    end
endmodule // cpu_model

//--- test/irq_ctrl_sva.sv
// Port-level checker for the interrupt controller.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/10ps
module irq_ctrl_chk
    import irq_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic cpu_ack_i,
    input wire logic cpu_reti_i,
    input wire logic irq_o,
    input wire logic [VEC_W-1:0] vector_o,
    input wire logic level_high_o,
    input wire logic [NUM_SRC-1:0] src_clr_o,
    input wire logic in_high_o,
    input wire logic in_low_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_take;
        irq_o && cpu_ack_i && ce_i;
    endsequence
    a_clr_onehot: assert property ($onehot0(src_clr_o))
        else $error("served pulse not one-hot");
    a_take_clr: assert property (s_take |=> !irq_o && src_clr_o != 13'h0000)
        else $error("ack not answered by a served pulse");
    a_clr_pulse: assert property (src_clr_o != 13'h0000 && ce_i |=> src_clr_o == 13'h0000)
        else $error("served pulse too long");
    a_ce_freeze: assert property (!ce_i |=> $stable(irq_o) && $stable(in_high_o) && $stable(in_low_o))
        else $error("state moved while clock enable low");
    a_vec_form: assert property (irq_o |-> vector_o[2:0] == 3'h3 && vector_o[15:7] == 9'h000)
        else $error("vector outside table");
    a_high_blocks: assert property (in_high_o |-> !irq_o)
        else $error("offer during high routine");
    a_low_held: assert property (in_low_o && irq_o |-> level_high_o)
        else $error("low offer during low routine");
    a_enter_high: assert property (s_take ##0 level_high_o |=> in_high_o)
        else $error("high entry not tracked");
    a_reti_leave: assert property (in_high_o && cpu_reti_i && ce_i && !cpu_ack_i |=> !in_high_o)
        else $error("high level not released");
    a_wake_vec: assert property (s_take ##1 src_clr_o[12] |-> $past(vector_o) == 16'h007B)
        else $error("wake-up served with wrong vector");
endmodule // irq_ctrl_chk
bind irq_ctrl irq_ctrl_chk u_irq_ctrl_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cpu_ack_i(cpu_ack_i), .cpu_reti_i(cpu_reti_i),
    .irq_o(irq_o), .vector_o(vector_o), .level_high_o(level_high_o), .src_clr_o(src_clr_o),
    .in_high_o(in_high_o), .in_low_o(in_low_o)
);

//--- test/tb_top.sv
// Self-checking bench for the interrupt controller with a CPU model.
// Assumes the design's outputs are registers on the rising edge.
`timescale 1ns/10ps
module tb_top;
    import irq_pkg::*;
    logic clock_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic [11:0] req = 12'h000;
    logic [11:0] high = 12'h000;
    logic pd = 1'h0;
    logic int0 = 1'h1;
    logic nom = 1'h0;
    logic reti_req = 1'h0;
    logic [3:0] dly = 4'h0;
    logic ce = 1'h1;
    logic gen = 1'h1;
    logic [11:0] en = 12'hFFF;
    logic ack, reti, irq, lvl, in_hi, in_lo, wake;
    logic [15:0] vec, taken;
    logic [12:0] clr;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    localparam logic [15:0] EXP [13] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
        16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B, 16'h007B};
    localparam int ORD [12] = '{0, 6, 1, 7, 2, 8, 3, 9, 4, 10, 5, 11};

    irq_ctrl u_irq_ctrl (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce), .glob_en_i(gen),
        .src_req_i(req), .src_en_i(en), .src_high_i(high), .pd_mode_i(pd), .int0_pin_i(int0),
        .clk_nominal_i(nom), .cpu_ack_i(ack), .cpu_reti_i(reti), .irq_o(irq), .vector_o(vec),
        .level_high_o(lvl), .src_clr_o(clr), .in_high_o(in_hi), .in_low_o(in_lo), .wake_pend_o(wake));
    cpu_model u_cpu_model (.clock_i(clock_i), .irq_i(irq), .vec_i(vec), .dly_i(dly), .reti_req_i(reti_req),
        .ack_o(ack), .reti_o(reti), .taken_o(taken));

    initial begin
        forever #50 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Waits for the served pulse, then judges source and vector
    task automatic take(input int i);
        int n;
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (clr === 13'h0000 && n < 80);
        chk("served", {3'h0, clr}, 16'(13'h0001 << i));
        chk("vector", taken, EXP[i]);
    endtask
    task automatic end_routine();
        reti_req <= 1'h1;
        @(negedge clock_i);
        reti_req <= 1'h0;
        @(negedge clock_i);
    endtask

    task automatic t_poll(input logic h);
        high = {12{h}};
        dly = h ? 4'h3 : 4'h0;
        req = 12'hFFF;
        for (int k = 0; k < 12; k++) begin
            take(ORD[k]);
            chk("in_level", {15'h0000, h ? in_hi : in_lo}, 16'h0001);
            req[ORD[k]] = 1'h0;
            end_routine();
        end
        $display("poll test done");
    endtask
    task automatic t_mixed();
        high = 12'h800;
        req = 12'h801;
        take(11);
        req[11] = 1'h0;
        end_routine();
        take(0);
        req = 12'h000;
        end_routine();
        $display("mixed test done");
    endtask
    task automatic t_nest();
        high = 12'h020;
        req = 12'h001;
        take(0);
        req = 12'h022;
        take(5);
        req[5] = 1'h0;
        repeat (8) @(negedge clock_i);
        chk("irq_in_high", {15'h0000, irq}, 16'h0000);
        end_routine();
        repeat (4) @(negedge clock_i);
        chk("levels", {14'h0000, in_hi, in_lo}, 16'h0001);
        chk("low_held", {15'h0000, irq}, 16'h0000);
        end_routine();
        take(1);
        req = 12'h000;
        end_routine();
        $display("nest test done");
    endtask
    task automatic t_wake();
        pd = 1'h1;
        int0 = 1'h0;
        repeat (6) @(negedge clock_i);
        chk("wake_pend", {15'h0000, wake}, 16'h0001);
        chk("irq_slow_clock", {15'h0000, irq}, 16'h0000);
        nom = 1'h1;
        pd = 1'h0;
        int0 = 1'h1;
        take(12);
        end_routine();
        chk("wake_done", {14'h0000, wake, in_hi}, 16'h0000);
        $display("wake test done");
    endtask
    // Enables, freeze and a mid-run reset with a high routine in service
    task automatic t_ctl();
        en = 12'hFFE;
        req = 12'h001;
        repeat (6) @(negedge clock_i);
        chk("src_masked", {15'h0000, irq}, 16'h0000);
        en = 12'hFFF;
        gen = 1'h0;
        repeat (6) @(negedge clock_i);
        chk("glob_masked", {15'h0000, irq}, 16'h0000);
        gen = 1'h1;
        ce = 1'h0;
        repeat (6) @(negedge clock_i);
        chk("frozen", {15'h0000, irq}, 16'h0000);
        ce = 1'h1;
        take(0);
        req = 12'h000;
        end_routine();
        req = 12'h020;
        take(5);
        req = 12'h000;
        chk("in_high", {15'h0000, in_hi}, 16'h0001);
        rst_n_i = 1'h0;
        repeat (3) @(negedge clock_i);
        rst_n_i = 1'h1;
        repeat (2) @(negedge clock_i);
        chk("reset_levels", {13'h0000, irq, in_hi, in_lo}, 16'h0000);
        $display("control test done");
    endtask

    initial begin
        repeat (12) @(negedge clock_i);
        rst_n_i = 1'h1;
        repeat (2) @(negedge clock_i);
        t_poll(1'h0);
        t_poll(1'h1);
        t_mixed();
        t_nest();
        t_wake();
        t_ctl();
        conclude();
    end
endmodule // tb_top
